// ==== bench/burst_trigger_decoder_sva.sv ====
`timescale 1ns/10ps
module burst_trigger_decoder_sva (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic choke_req_i,
  input wire logic error_req_i,
  input wire logic frame_valid_o,
  input wire logic [2:0] frame_kind_o,
  input wire logic [5:0] frame_type_o,
  input wire logic data_taking_o,
  input wire logic choke_o,
  input wire logic error_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Frame of one type
  sequence typed(logic [5:0] t);
    frame_valid_o && frame_type_o == t;
  endsequence

  chk_one_frame: assert property (frame_valid_o |=> !frame_valid_o)
    else $error("frame valid held");
  chk_physics_event: assert property (frame_valid_o && !frame_type_o[5] &&
    frame_kind_o != burst_trigger_pkg::FRAME_EMPTY |-> frame_kind_o == burst_trigger_pkg::FRAME_EVENT)
    else $error("physics frame kind");
  chk_sync_frame: assert property (typed(6'h20) |-> frame_kind_o == burst_trigger_pkg::FRAME_SYNC)
    else $error("sync frame kind");
  chk_start_enables: assert property (typed(6'h22) |->
    frame_kind_o == burst_trigger_pkg::FRAME_SPECIAL ##[0:3] data_taking_o)
    else $error("start type handling");
  chk_end_disables: assert property (typed(6'h23) |->
    frame_kind_o == burst_trigger_pkg::FRAME_EOB ##[0:3] !data_taking_o)
    else $error("end type handling");
  chk_special_frame: assert property (frame_valid_o && frame_type_o inside {6'h24, 6'h25, 6'h26, 6'h2F}
    |-> frame_kind_o == burst_trigger_pkg::FRAME_SPECIAL)
    else $error("special frame kind");
  chk_monitor_frame: assert property (typed(6'h28) |-> frame_kind_o == burst_trigger_pkg::FRAME_MONITOR)
    else $error("monitor frame kind");
  chk_random_event: assert property (frame_valid_o && frame_type_o[5:1] == 5'h16
    |-> frame_kind_o == burst_trigger_pkg::FRAME_EVENT)
    else $error("random frame kind");
  chk_reserved_empty: assert property (frame_valid_o && frame_type_o inside {6'h21, 6'h29, 6'h2A, 6'h2B, 6'h2E}
    |-> frame_kind_o == burst_trigger_pkg::FRAME_EMPTY)
    else $error("reserved frame kind");
  chk_choke_rise: assert property (choke_req_i |-> ##[0:2] choke_o)
    else $error("choke not raised");
  chk_choke_hold: assert property ($fell(choke_o) |-> !$past(choke_req_i))
    else $error("choke dropped under request");
  chk_error_hold: assert property ($fell(error_o) |-> !$past(error_req_i))
    else $error("error dropped under request");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`include "burst_trigger_regs.svh"
module testbench;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, choke_req_i = 1'b0, error_req_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic trig_pulse_i, bcast_strobe_i, frame_valid_o, data_taking_o, choke_o, error_o;
  logic [11:0] fine_ts_i;
  logic [7:0] bcast_word_i;
  logic [31:0] reg_rdata_o, frame_ts_o, frame_cycles_o, frame_eob_ts_o, frame_trig_count_o, f_ts;
  logic [2:0] frame_kind_o, f_kind;
  logic [5:0] frame_type_o, f_type;
  int frames = 0, bad_count = 0, checks = 0, cycles = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  burst_trigger_decoder dut_u (.ref_clk_i, .rst_n_i, .trig_pulse_i, .fine_ts_i, .bcast_strobe_i, .bcast_word_i,
    .choke_req_i, .error_req_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frame_valid_o,
    .frame_kind_o, .frame_type_o, .frame_ts_o, .frame_cycles_o, .frame_eob_ts_o, .frame_trig_count_o,
    .data_taking_o, .choke_o, .error_o);
  trigger_source_model model_u (.ref_clk_i(ref_clk_i), .trig_pulse_o(trig_pulse_i), .fine_ts_o(fine_ts_i),
    .bcast_strobe_o(bcast_strobe_i), .bcast_word_o(bcast_word_i));

  // Frame latch and hang ceiling
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (frame_valid_o === 1'b1) begin
      f_kind <= frame_kind_o;
      f_type <= frame_type_o;
      f_ts <= frame_ts_o;
      frames <= frames + 1;
    end
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data stand one cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic wait_frame(input int n);
    for (int i = 0; i < 40 && frames == n; i++) @(posedge ref_clk_i);
    #1 check("frame seen", 1, frames != n);
  endtask

  // Pulse, type, answer
  task automatic trig(input logic [5:0] t, output logic [31:0] at);
    int n;
    logic [31:0] w;
    n = frames;
    model_u.pulse(at);
    model_u.word({t, 2'b00}, w);
    wait_frame(n);
  endtask

  task automatic settle(output logic [31:0] d);
    repeat (6) @(posedge ref_clk_i);
    reg_read(`BT_REG_STATUS, d);
  endtask

  task automatic test_regs();
    logic [31:0] d, at;
    reg_read(`BT_REG_CTRL, d);
    check("ctrl reset", `BT_CTRL_RESET, d);
    reg_write(8'h40, 32'hFFFF_FFFF);
    reg_read(8'h40, d);
    check("unmapped read", 0, d);
    reg_write(`BT_REG_COARSE_OFS, 32'h0001_2345);
    reg_read(`BT_REG_COARSE_OFS, d);
    check("coarse ofs", 32'h0001_2345, d);
    reg_write(`BT_REG_CTRL, 32'h0000_0000);
    trig(6'h30, at);
    check("calib off kind", 5, f_kind);
    reg_write(`BT_REG_CTRL, `BT_CTRL_RESET);
    $display("test_regs done");
  endtask

  // Kind above type
  task automatic test_types();
    logic [8:0] tbl [17] = '{9'h005, 9'h060, 9'h0A2, 9'h0A4, 9'h0A5, 9'h0A6, 9'h0AF, 9'h128, 9'h02C,
      9'h02D, 9'h030, 9'h03F, 9'h161, 9'h169, 9'h16A, 9'h16E, 9'h0E3};
    logic [31:0] at, d;
    foreach (tbl[i]) begin
      trig(tbl[i][5:0], at);
      check("frame kind", tbl[i][8:6], f_kind);
      check("frame type", tbl[i][5:0], f_type);
      if (tbl[i][5:0] == 6'h22) check("taking", 1, data_taking_o);
    end
    check("taking", 0, data_taking_o);
    reg_read(`BT_REG_STATUS, d);
    check("unknown flag", 1, d[3]);
    $display("test_types done");
  endtask

  // Second pulse before type: empty frame
  task automatic test_orphan();
    logic [31:0] at, w;
    int n;
    n = frames;
    model_u.pulse(at);
    model_u.pulse(at);
    wait_frame(n);
    check("orphan kind", 5, f_kind);
    n = frames;
    model_u.word({6'h07, 2'b00}, w);
    wait_frame(n);
    check("paired type", 7, f_type);
    $display("test_orphan done");
  endtask

  task automatic test_choke();
    logic [31:0] at;
    @(posedge ref_clk_i);
    choke_req_i <= 1'b1;
    error_req_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    choke_req_i <= 1'b0;
    error_req_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    #1 check("choke held", 1, choke_o);
    check("error held", 1, error_o);
    trig(6'h24, at);
    repeat (3) @(posedge ref_clk_i);
    #1 check("choke ack", 0, choke_o);
    check("error waits", 1, error_o);
    trig(6'h26, at);
    repeat (3) @(posedge ref_clk_i);
    #1 check("error ack", 0, error_o);
    $display("test_choke done");
  endtask

  task automatic test_seq();
    logic [31:0] at, w, d;
    model_u.word(8'h01, w);
    settle(d);
    check("reserved code", 0, d[2:1]);
    model_u.word({6'h00, `BT_BURST_END}, w);
    settle(d);
    check("seq error", 1, d[2]);
    check("error line", 1, error_o);
    reg_write(`BT_REG_STATUS, 32'h0000_0004);
    reg_read(`BT_REG_STATUS, d);
    check("seq cleared", 0, d[2]);
    trig(6'h26, at);
    check("error ack", 0, error_o);
    $display("test_seq done");
  endtask

  // Stamps and cycle counts per burst
  task automatic test_burst();
    logic [31:0] a1, a2, a3, t1, s1, e1, s2, e2, c1, d;
    while (model_u.count[11:0] != 12'h064) @(posedge ref_clk_i);
    reg_write(`BT_REG_COARSE_OFS, 32'h0000_0ABC);
    model_u.word({6'h00, `BT_BURST_START}, s1);
    trig(6'h05, a1);
    t1 = f_ts;
    check("coarse start", 32'h0000_0ABC, t1[31:12]);
    reg_read(`BT_REG_STATUS, d);
    check("burst active", 1, d[1]);
    repeat (4100) @(posedge ref_clk_i);
    trig(6'h05, a2);
    check("stamp step", a2 - a1, f_ts - t1);
    reg_write(`BT_REG_CTRL, `BT_CTRL_RESET | 32'h0000_0007);
    trig(6'h05, a3);
    check("offset stamp", a3 - a1 - 32'h0000_0007, f_ts - t1);
    reg_write(`BT_REG_CTRL, `BT_CTRL_RESET);
    model_u.word({6'h00, `BT_BURST_END}, e1);
    settle(d);
    check("burst over", 0, d[2:1]);
    reg_read(`BT_REG_BURST_CYCLES, c1);
    model_u.word({6'h00, `BT_BURST_START}, s2);
    repeat (50) @(posedge ref_clk_i);
    model_u.word({6'h00, `BT_BURST_END}, e2);
    settle(d);
    reg_read(`BT_REG_BURST_CYCLES, d);
    check("cycle count", (e2 - s2) - (e1 - s1), d - c1);
    $display("test_burst done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    test_regs();
    test_types();
    test_orphan();
    test_choke();
    test_seq();
    test_burst();
    conclude();
  end
endmodule

bind burst_trigger_decoder burst_trigger_decoder_sva chk_u (.ref_clk_i, .rst_n_i, .choke_req_i, .error_req_i,
  .frame_valid_o, .frame_kind_o, .frame_type_o, .data_taking_o, .choke_o, .error_o);

// ==== bench/trigger_source_model.sv ====
`timescale 1ns/10ps
module trigger_source_model (
  input wire logic ref_clk_i,
  output logic trig_pulse_o,
  output logic [11:0] fine_ts_o,
  output logic bcast_strobe_o,
  output logic [7:0] bcast_word_o
);
  logic [31:0] count = 32'h0000_0000;
  logic [31:0] last_trig = 32'h0000_0000;

  // Free-running count
  always @(posedge ref_clk_i) count <= count + 32'h1;
  assign fine_ts_o = count[11:0];

  // Released word shows the inverse
  initial begin
    trig_pulse_o = 1'b0;
    bcast_strobe_o = 1'b0;
    bcast_word_o = 8'hA5;
  end

  // One-period pulse, spaced and in time order
  task automatic pulse(output logic [31:0] at);
    while (count - last_trig < 32'h4) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    trig_pulse_o <= 1'b1;
    at = count;
    last_trig = count;
    @(posedge ref_clk_i);
    trig_pulse_o <= 1'b0;
  endtask

  // Held four cycles for the late sampler
  task automatic word(input logic [7:0] w, output logic [31:0] at);
    @(posedge ref_clk_i);
    bcast_word_o <= w;
    bcast_strobe_o <= 1'b1;
    at = count;
    repeat (4) @(posedge ref_clk_i);
    bcast_strobe_o <= 1'b0;
    bcast_word_o <= ~w;
  endtask
endmodule

// ==== rtl/burst_sequence_checker.sv ====
`timescale 1ns/10ps
`include "burst_trigger_regs.svh"

module burst_sequence_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_i,
  input wire logic clear_error_i,
  output logic start_o,
  output logic end_o,
  output logic burst_active_o,
  output logic seq_error_o
);

  logic is_start;
  logic is_end;

  // Reserved code 01 and 00 carry no burst command
  assign is_start = cmd_valid_i && (cmd_i == `BT_BURST_START);
  assign is_end = cmd_valid_i && (cmd_i == `BT_BURST_END);
  assign start_o = is_start;
  assign end_o = is_end && burst_active_o;

  // A repeated start still opens a fresh burst so counters do not run away
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      burst_active_o <= 1'b0;
    end else if (is_start) begin
      burst_active_o <= 1'b1;
    end else if (is_end) begin
      burst_active_o <= 1'b0;
    end
  end

  // Out-of-order command marks the burst lost; a new error beats the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      seq_error_o <= 1'b0;
    end else if ((is_start && burst_active_o) || (is_end && !burst_active_o)) begin
      seq_error_o <= 1'b1;
    end else if (clear_error_i) begin
      seq_error_o <= 1'b0;
    end
  end

endmodule

// ==== rtl/burst_timestamp_counter.sv ====
`timescale 1ns/10ps
`include "burst_trigger_regs.svh"

module burst_timestamp_counter #(
  parameter int FINE_W = `BT_FINE_W,
  parameter int COARSE_W = `BT_COARSE_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [FINE_W-1:0] fine_i,
  input wire logic start_i,
  input wire logic active_i,
  input wire logic [COARSE_W-1:0] coarse_offset_i,
  input wire logic [FINE_W-1:0] fine_offset_i,
  output logic [FINE_W+COARSE_W-1:0] timestamp_o,
  output logic [31:0] burst_cycles_o
);

  logic [FINE_W-1:0] fine_prev;
  logic [COARSE_W-1:0] coarse;
  logic fine_wrap;
  logic fine_step;

  // Fine count wrap is the divided master clock stepping the coarse count
  assign fine_wrap = fine_prev[FINE_W-1] & ~fine_i[FINE_W-1];
  assign fine_step = (fine_i != fine_prev);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fine_prev <= '0;
    end else begin
      fine_prev <= fine_i;
    end
  end

  // Coarse count, preloaded at burst start with the coarse offset register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      coarse <= '0;
    end else if (start_i) begin
      coarse <= coarse_offset_i;
    end else if (fine_wrap) begin
      coarse <= coarse + 1'b1;
    end
  end

  // Experiment clock cycles seen inside the burst
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      burst_cycles_o <= '0;
    end else if (start_i) begin
      burst_cycles_o <= '0;
    end else if (active_i && fine_step) begin
      burst_cycles_o <= burst_cycles_o + 32'h0000_0001;
    end
  end

  // Full stamp minus the local fibre correction; the wrap cycle carries early so no stamp goes back
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      timestamp_o <= '0;
    end else begin
      timestamp_o <= {coarse + fine_wrap, fine_i} - {{COARSE_W{1'b0}}, fine_offset_i};
    end
  end

endmodule

// ==== rtl/burst_trigger_decoder.sv ====
//Operation
// - Trigger is one-period pulse; time from it
// - Burst start clears local timestamp counters
// - Apply extra per-detector fine offset locally
// - Fine stamp twelve bits, wraps each 4096
// - Coarse count above fine, preloaded offset
// - Type word follows pulse, pairs with it
// - Broadcast: low two burst bits, six type
// - Top bit clear: physics, read event data
// - Sync type answers with event-shaped frame
// - Start type enables taking, special frame
// - End type disables taking, end data
// - Choke and error types get special frame
// - Monitoring type sends monitoring frame
// - Random and calibration read data per type
// - Every trigger answered, empty if unhandled
// - End frame carries stats and end stamp
// - Burst bits: 11 start, 10 end, 01 reserved
// - Out-of-order burst command is serious error
// - Count clock cycles from start to end
// - Thirty-two bit burst cycle counter
// - Hold choke/error until matching acknowledge type
// - One continuous experiment clock times all
`timescale 1ns/10ps
`include "burst_trigger_regs.svh"

module burst_trigger_decoder #(
  parameter int FINE_W = `BT_FINE_W,
  parameter int COARSE_W = `BT_COARSE_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic trig_pulse_i,
  input wire logic [FINE_W-1:0] fine_ts_i,
  input wire logic bcast_strobe_i,
  input wire logic [7:0] bcast_word_i,
  input wire logic choke_req_i,
  input wire logic error_req_i,
  input wire logic [`BT_ADDR_W-1:0] reg_addr_i,
  input wire logic [`BT_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`BT_DATA_W-1:0] reg_rdata_o,
  output logic frame_valid_o,
  output logic [2:0] frame_kind_o,
  output logic [5:0] frame_type_o,
  output logic [FINE_W+COARSE_W-1:0] frame_ts_o,
  output logic [31:0] frame_cycles_o,
  output logic [FINE_W+COARSE_W-1:0] frame_eob_ts_o,
  output logic [31:0] frame_trig_count_o,
  output logic data_taking_o,
  output logic choke_o,
  output logic error_o
);

  localparam int TS_W = FINE_W + COARSE_W;
  localparam int SYNC_W = FINE_W + 10;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_line;
  logic trig_prev;
  logic strobe_prev;
  logic trig_rise;
  logic strobe_rise;
  logic [FINE_W-1:0] fine_sync;
  logic [7:0] word_sync;
  logic [5:0] type_field;
  logic [1:0] burst_field;

  logic [`BT_DATA_W-1:0] ctrl;
  logic [COARSE_W-1:0] coarse_ofs;
  logic burst_start;
  logic burst_end;
  logic burst_active;
  logic seq_error;
  logic clear_seq;
  logic [TS_W-1:0] timestamp;
  logic [31:0] burst_cycles;
  logic [TS_W-1:0] eob_ts;
  logic [31:0] trig_count;
  logic [TS_W-1:0] pending_ts;
  logic unknown_type;
  logic choke_acked;
  logic error_acked;
  logic error_cause;
  burst_trigger_pkg::decode_state_type state;
  burst_trigger_pkg::decode_state_type next_state;
  logic type_taken;
  logic orphan;
  burst_trigger_pkg::frame_kind_type next_kind;
  logic next_unknown;

  // Pins from the timing receiver cross two flip-flops first.
  // Fine count may tear while it steps; a single bad sample only moves one stamp.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync_meta <= '0;
      sync_line <= '0;
    end else begin
      sync_meta <= {trig_pulse_i, bcast_strobe_i, bcast_word_i, fine_ts_i};
      sync_line <= sync_meta;
    end
  end

  assign fine_sync = sync_line[FINE_W-1:0];
  assign word_sync = sync_line[FINE_W+7:FINE_W];

  // Edge history reads only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      trig_prev <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      trig_prev <= sync_line[SYNC_W-1];
      strobe_prev <= sync_line[SYNC_W-2];
    end
  end

  // A pulse of one experiment period gives exactly one rising edge
  assign trig_rise = sync_line[SYNC_W-1] & ~trig_prev;
  assign strobe_rise = sync_line[SYNC_W-2] & ~strobe_prev;
  assign type_field = word_sync[7:2];
  assign burst_field = word_sync[1:0];

  // Burst command sequence and timestamp keeping
  burst_sequence_checker u_seq (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .cmd_valid_i(strobe_rise),
    .cmd_i(burst_field),
    .clear_error_i(clear_seq),
    .start_o(burst_start),
    .end_o(burst_end),
    .burst_active_o(burst_active),
    .seq_error_o(seq_error)
  );

  burst_timestamp_counter #(
    .FINE_W(FINE_W),
    .COARSE_W(COARSE_W)
  ) u_ts (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .fine_i(fine_sync),
    .start_i(burst_start),
    .active_i(burst_active),
    .coarse_offset_i(coarse_ofs),
    .fine_offset_i(ctrl[`BT_CTRL_OFS_MSB:`BT_CTRL_OFS_LSB]),
    .timestamp_o(timestamp),
    .burst_cycles_o(burst_cycles)
  );

  // Type decode: which answer frame each type gets
  always_comb begin
    next_kind = burst_trigger_pkg::FRAME_EMPTY;
    next_unknown = 1'b0;
    if (!type_field[5]) begin
      next_kind = burst_trigger_pkg::FRAME_EVENT;
    end else if (type_field[5:4] == `BT_TYPE_CALIB_PFX) begin
      // Calibration for another detector may be answered empty
      next_kind = ctrl[`BT_CTRL_CALIB_EN] ? burst_trigger_pkg::FRAME_EVENT
                                           : burst_trigger_pkg::FRAME_EMPTY;
    end else if (type_field[5:1] == `BT_TYPE_RANDOM_PFX) begin
      next_kind = burst_trigger_pkg::FRAME_EVENT;
    end else begin
      case (type_field)
        `BT_TYPE_SYNC: begin
          next_kind = burst_trigger_pkg::FRAME_SYNC;
        end
        `BT_TYPE_SOB: begin
          next_kind = burst_trigger_pkg::FRAME_SPECIAL;
        end
        `BT_TYPE_EOB: begin
          next_kind = burst_trigger_pkg::FRAME_EOB;
        end
        `BT_TYPE_CHOKE_ON, `BT_TYPE_CHOKE_OFF, `BT_TYPE_ERR_ON, `BT_TYPE_ERR_OFF: begin
          next_kind = burst_trigger_pkg::FRAME_SPECIAL;
        end
        `BT_TYPE_MONITOR: begin
          next_kind = burst_trigger_pkg::FRAME_MONITOR;
        end
        default: begin
          next_kind = burst_trigger_pkg::FRAME_EMPTY;
          next_unknown = 1'b1;
        end
      endcase
    end
  end

  // Pairing of pulse and following type word
  assign type_taken = (state == burst_trigger_pkg::ST_AWAIT_TYPE) && strobe_rise;
  assign orphan = (state == burst_trigger_pkg::ST_AWAIT_TYPE) && trig_rise && !strobe_rise;

  always_comb begin
    case (state)
      burst_trigger_pkg::ST_IDLE: begin
        next_state = trig_rise ? burst_trigger_pkg::ST_AWAIT_TYPE : burst_trigger_pkg::ST_IDLE;
      end
      burst_trigger_pkg::ST_AWAIT_TYPE: begin
        if (trig_rise) begin
          next_state = burst_trigger_pkg::ST_AWAIT_TYPE;
        end else if (strobe_rise) begin
          next_state = burst_trigger_pkg::ST_IDLE;
        end else begin
          next_state = burst_trigger_pkg::ST_AWAIT_TYPE;
        end
      end
      default: begin
        next_state = burst_trigger_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= burst_trigger_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Stamp taken in the cycle of the pulse edge; a type in the same cycle belongs to the older pulse
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pending_ts <= '0;
    end else if (trig_rise) begin
      pending_ts <= timestamp;
    end
  end

  // Answer frame: typed, or empty when a new pulse arrives before the type
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      frame_valid_o <= 1'b0;
      frame_kind_o <= burst_trigger_pkg::FRAME_EMPTY;
      frame_type_o <= '0;
      frame_ts_o <= '0;
    end else begin
      frame_valid_o <= type_taken || orphan;
      if (type_taken) begin
        frame_kind_o <= next_kind;
        frame_type_o <= type_field;
        frame_ts_o <= pending_ts;
      end else if (orphan) begin
        frame_kind_o <= burst_trigger_pkg::FRAME_EMPTY;
        frame_type_o <= '0;
        frame_ts_o <= pending_ts;
      end
    end
  end

  // Burst statistics latched on every typed frame (orphan empty frames keep the last ones), meaningful on the end frame
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      frame_cycles_o <= '0;
      frame_eob_ts_o <= '0;
      frame_trig_count_o <= '0;
    end else if (type_taken) begin
      frame_cycles_o <= burst_cycles;
      frame_eob_ts_o <= eob_ts;
      frame_trig_count_o <= trig_count;
    end
  end

  // Stamp at the hardware end command, kept for the end frame
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      eob_ts <= '0;
    end else if (burst_end) begin
      eob_ts <= timestamp;
    end
  end

  // Triggers seen since the last burst start, ends included
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      trig_count <= '0;
    end else if (burst_start) begin
      trig_count <= '0;
    end else if (trig_rise) begin
      trig_count <= trig_count + 32'h0000_0001;
    end
  end

  // Data-taking window follows the start and end trigger types
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      data_taking_o <= 1'b0;
    end else if (type_taken && type_field == `BT_TYPE_SOB) begin
      data_taking_o <= 1'b1;
    end else if (type_taken && type_field == `BT_TYPE_EOB) begin
      data_taking_o <= 1'b0;
    end
  end

  // Sticky unknown type flag; a new event wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      unknown_type <= 1'b0;
    end else if (type_taken && next_unknown) begin
      unknown_type <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `BT_REG_STATUS && reg_wdata_i[`BT_STAT_UNKNOWN]) begin
      unknown_type <= 1'b0;
    end
  end

  assign clear_seq = reg_wr_i && (reg_addr_i == `BT_REG_STATUS) && reg_wdata_i[`BT_STAT_SEQ_ERR];
  assign error_cause = error_req_i | ctrl[`BT_CTRL_ERR_REQ] | seq_error;

  // Choke stays up until acknowledged, even if the cause has gone
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      choke_o <= 1'b0;
      choke_acked <= 1'b0;
    end else if (choke_req_i) begin
      choke_o <= 1'b1;
      if (choke_o && type_taken && type_field == `BT_TYPE_CHOKE_ON) begin
        choke_acked <= 1'b1;
      end
    end else if (choke_o && (choke_acked || (type_taken && type_field == `BT_TYPE_CHOKE_ON))) begin
      choke_o <= 1'b0;
      choke_acked <= 1'b0;
    end
  end

  // Error line held the same way against the error-on acknowledge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      error_o <= 1'b0;
      error_acked <= 1'b0;
    end else if (error_cause) begin
      error_o <= 1'b1;
      if (error_o && type_taken && type_field == `BT_TYPE_ERR_ON) begin
        error_acked <= 1'b1;
      end
    end else if (error_o && (error_acked || (type_taken && type_field == `BT_TYPE_ERR_ON))) begin
      error_o <= 1'b0;
      error_acked <= 1'b0;
    end
  end

  // Software writable settings
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= `BT_CTRL_RESET;
      coarse_ofs <= `BT_COARSE_OFS_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `BT_REG_CTRL) begin
        ctrl <= reg_wdata_i;
      end
      if (reg_addr_i == `BT_REG_COARSE_OFS) begin
        coarse_ofs <= reg_wdata_i[COARSE_W-1:0];
      end
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `BT_REG_CTRL: begin
          reg_rdata_o <= ctrl;
        end
        `BT_REG_STATUS: begin
          reg_rdata_o <= '0;
          reg_rdata_o[`BT_STAT_TAKING] <= data_taking_o;
          reg_rdata_o[`BT_STAT_ACTIVE] <= burst_active;
          reg_rdata_o[`BT_STAT_SEQ_ERR] <= seq_error;
          reg_rdata_o[`BT_STAT_UNKNOWN] <= unknown_type;
          reg_rdata_o[`BT_STAT_CHOKE] <= choke_o;
          reg_rdata_o[`BT_STAT_ERROR] <= error_o;
          reg_rdata_o[`BT_STAT_AWAIT] <= (state == burst_trigger_pkg::ST_AWAIT_TYPE);
        end
        `BT_REG_COARSE_OFS: begin
          reg_rdata_o <= {{(`BT_DATA_W-COARSE_W){1'b0}}, coarse_ofs};
        end
        `BT_REG_BURST_CYCLES: begin
          reg_rdata_o <= burst_cycles;
        end
        `BT_REG_EOB_TS: begin
          reg_rdata_o <= eob_ts[`BT_DATA_W-1:0];
        end
        `BT_REG_TRIG_COUNT: begin
          reg_rdata_o <= trig_count;
        end
        `BT_REG_LAST_TS: begin
          reg_rdata_o <= pending_ts[`BT_DATA_W-1:0];
        end
        default: begin
          reg_rdata_o <= '0;
        end
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

// ==== rtl/burst_trigger_pkg.sv ====
package burst_trigger_pkg;

  // Answer frame kinds sent per trigger
  typedef enum logic [2:0] {
    FRAME_EVENT,
    FRAME_SYNC,
    FRAME_SPECIAL,
    FRAME_EOB,
    FRAME_MONITOR,
    FRAME_EMPTY
  } frame_kind_type;

  // Trigger pulse / type pairing
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_AWAIT_TYPE
  } decode_state_type;

endpackage

// ==== rtl/burst_trigger_regs.svh ====
`ifndef BURST_TRIGGER_REGS_SVH
`define BURST_TRIGGER_REGS_SVH

// Register bus geometry
`define BT_ADDR_W 8
`define BT_DATA_W 32

// Register byte offsets
`define BT_REG_CTRL 8'h00
`define BT_REG_STATUS 8'h04
`define BT_REG_COARSE_OFS 8'h08
`define BT_REG_BURST_CYCLES 8'h0C
`define BT_REG_EOB_TS 8'h10
`define BT_REG_TRIG_COUNT 8'h14
`define BT_REG_LAST_TS 8'h18

// Control fields
`define BT_CTRL_OFS_LSB 0
`define BT_CTRL_OFS_MSB 11
`define BT_CTRL_CALIB_EN 16
`define BT_CTRL_ERR_REQ 17
`define BT_CTRL_RESET 32'h0001_0000
`define BT_COARSE_OFS_RESET 20'h0_0000

// Status fields
`define BT_STAT_TAKING 0
`define BT_STAT_ACTIVE 1
`define BT_STAT_SEQ_ERR 2
`define BT_STAT_UNKNOWN 3
`define BT_STAT_CHOKE 4
`define BT_STAT_ERROR 5
`define BT_STAT_AWAIT 6

// Timestamp layout
`define BT_FINE_W 12
`define BT_COARSE_W 20
`define BT_TS_W 32

// Broadcast word layout and burst codes (bunch bit 1, event bit 0)
`define BT_BURST_START 2'h3
`define BT_BURST_END 2'h2

// Trigger type codes
`define BT_TYPE_SYNC 6'h20
`define BT_TYPE_SOB 6'h22
`define BT_TYPE_EOB 6'h23
`define BT_TYPE_CHOKE_ON 6'h24
`define BT_TYPE_CHOKE_OFF 6'h25
`define BT_TYPE_ERR_ON 6'h26
`define BT_TYPE_ERR_OFF 6'h2F
`define BT_TYPE_MONITOR 6'h28
`define BT_TYPE_RANDOM_PFX 5'h16
`define BT_TYPE_CALIB_PFX 2'h3

`endif
